// File: verilog/rcr_map.svh
// register offsets, field positions, keys and timing constants for reset cause and retention
`ifndef RCR_MAP_SVH
`define RCR_MAP_SVH
`define RCR_OFF_CONFIG 32'h4000_2408
`define RCR_OFF_KEY 32'h4000_240c
`define RCR_OFF_CAUSE 32'h4000_2440
`define RCR_OFF_RETAIN 32'h4008_2c34
`define RCR_OFF_IRQ_MASK 32'h4000_2444
`define RCR_OFF_CTRL 32'h4000_2448
`define RCR_ADDR_LSB 2
`define RCR_KEY_FIRST 16'h2009
`define RCR_KEY_SECOND 16'h0426
`define RCR_SYSRST_KEY 16'h05fa
`define RCR_BIT_POR 0
`define RCR_BIT_EXT 1
`define RCR_BIT_WDT 2
`define RCR_BIT_SW 3
`define RCR_BIT_RETAIN 0
`define RCR_CAUSE_W 4
`define RCR_RESP_OKAY 2'h0
`define RCR_RESP_SLVERR 2'h2
`define RCR_CLK_HZ 40000000
`define RCR_WDT_TIMEOUT_S 32
`endif

// File: verilog/rcr_pkg.sv
// types shared by the reset cause and retention block
package rcr_pkg;
  typedef enum logic [2:0] {
    RCR_LOCKED,
    RCR_KEY1_SEEN,
    RCR_OPEN
  } rcr_key_state_t;
  typedef enum logic [2:0] {
    RCR_RST_NONE,
    RCR_RST_POR,
    RCR_RST_EXT,
    RCR_RST_WDT,
    RCR_RST_SW
  } rcr_rst_kind_t;
endpackage

// File: verilog/rcr_sync.sv
// two flip-flop synchroniser for asynchronous reset source levels
`timescale 1ns/1ps
module rcr_sync #(
  parameter int W = 1
) (
  input wire logic mclk, // system clock
  input wire logic srst, // synchronous reset, active high
  input wire logic ce, // clock enable
  input wire logic [W-1:0] d, // asynchronous level in
  output logic [W-1:0] q // synchronised level out
);
  logic [W-1:0] meta_r;
  // first stage read only by the second stage
  always_ff @(posedge mclk) begin
    if (srst) begin
      meta_r <= '0;
      q <= '0;
    end else if (ce) begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // rcr_sync

// File: verilog/rcr_reset_ctrl.sv
// reset cause recording, retention control and key-protected configuration
`include "rcr_map.svh"
`timescale 1ns/1ps
// Contract
// - four reset sources: pin, power-on, watchdog, software
// - core reset register key 0x05FA means software reset
// - analog die retained unless retain control set
// - gpio and logic array retained unless config 0x1
// - config writable only after keys 0x2009, 0x0426
// - cause register holds until software clears
// - cause bits: 3 sw, 2 wdt, 1 ext, 0 por
// - write one clears bit, zero leaves it
// - watchdog enabled after reset, about 32 s
// - por indication low only during power-on reset
// - sram invalid after por or post-download reset
// - pin reset clears everything regardless of retention
// - other bus write between keys and config relocks
// - retain bit 0: 0 keeps, 1 resets analog die
module rcr_reset_ctrl #(
  parameter longint unsigned WDT_CYCLES = 64'(`RCR_WDT_TIMEOUT_S) * 64'(`RCR_CLK_HZ)
) (
  input wire logic mclk, // system clock, 40 MHz
  input wire logic srst, // bus-side synchronous reset, active high
  input wire logic ce, // clock enable, freezes state when low
  input wire logic por_n_pin, // power-on detector, low during power-on
  input wire logic ext_rst_n_pin, // external reset pin, active low
  input wire logic wdt_timeout, // watchdog timeout pulse, same clock
  input wire logic dl_done, // management firmware download completed pulse
  input wire logic core_rst_wr, // core reset control register write strobe
  input wire logic [31:0] core_rst_wdata, // core reset control write data
  input wire logic other_apb_wr, // write to any other peripheral register
  input wire logic [31:0] s_axi_awaddr, // axi write address
  input wire logic s_axi_awvalid, // axi write address valid
  output logic s_axi_awready, // axi write address ready
  input wire logic [31:0] s_axi_wdata, // axi write data
  input wire logic [3:0] s_axi_wstrb, // axi write strobes
  input wire logic s_axi_wvalid, // axi write data valid
  output logic s_axi_wready, // axi write data ready
  output logic [1:0] s_axi_bresp, // axi write response
  output logic s_axi_bvalid, // axi write response valid
  input wire logic s_axi_bready, // axi write response ready
  input wire logic [31:0] s_axi_araddr, // axi read address
  input wire logic s_axi_arvalid, // axi read address valid
  output logic s_axi_arready, // axi read address ready
  output logic [31:0] s_axi_rdata, // axi read data
  output logic [1:0] s_axi_rresp, // axi read response
  output logic s_axi_rvalid, // axi read valid
  input wire logic s_axi_rready, // axi read ready
  output logic sys_rst_req, // pulse: system reset to be applied
  output logic digital_rst, // pulse: reset mmrs and peripherals
  output logic io_pla_rst, // pulse: reset gpio and logic array
  output logic analog_die_rst, // pulse: reset analog die
  output logic por_ind_n, // power-on indication pin, low only in por
  output logic sram_valid, // sram contents may be trusted
  output logic wdt_enable, // watchdog enable after reset
  output logic [63:0] wdt_timeout_cycles, // watchdog default timeout in cycles
  output logic irq // level interrupt, unmasked cause set
);
  // ***********************************
  // synchronisers and event detection
  // ***********************************
  logic [1:0] pin_sync;
  logic por_n_s, ext_n_s, ext_n_d_r, por_n_d_r;
  rcr_sync #(.W(2)) u_sync (
    .mclk(mclk),
    .srst(1'b0),
    .ce(ce),
    .d({por_n_pin, ext_rst_n_pin}),
    .q(pin_sync)
  );
  assign por_n_s = pin_sync[1];
  assign ext_n_s = pin_sync[0];
  // delayed copies start at the idle level, so reset never looks like an edge
  always_ff @(posedge mclk) begin
    if (srst) begin
      ext_n_d_r <= 1'b1;
      por_n_d_r <= 1'b1;
    end else if (ce) begin
      ext_n_d_r <= ext_n_s;
      por_n_d_r <= por_n_s;
    end
  end
  logic ev_por, ev_ext, ev_wdt, ev_sw;
  // falling edge of each active-low level starts one event, the pin's only while the power-on level is high
  assign ev_por = por_n_d_r & ~por_n_s;
  assign ev_ext = ext_n_d_r & ~ext_n_s & por_n_s;
  assign ev_wdt = wdt_timeout;
  assign ev_sw = core_rst_wr & (core_rst_wdata[31:16] == `RCR_SYSRST_KEY);
  logic any_ev;
  assign any_ev = ev_por | ev_ext | ev_wdt | ev_sw;

  // ***********************************
  // bus slave
  // ***********************************
  logic aw_held_r, w_held_r;
  logic [31:0] awaddr_r, wdata_r;
  logic [3:0] wstrb_r;
  logic do_wr, do_rd;
  assign do_wr = aw_held_r & w_held_r & ~s_axi_bvalid;
  assign do_rd = s_axi_arvalid & s_axi_arready;
  // word address compare, low address bits ignored
  function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
    hit = (a[31:`RCR_ADDR_LSB] == off[31:`RCR_ADDR_LSB]);
  endfunction
  // channel capture, either order accepted
  always_ff @(posedge mclk) begin
    if (srst) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 32'h0000_0000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (do_wr) begin
        w_held_r <= 1'b0;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (ce) begin
      s_axi_awready <= ~aw_held_r & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= ~w_held_r & ~(s_axi_wvalid & s_axi_wready);
    end
  end
  logic wr_cfg, wr_key, wr_cause, wr_ret, wr_mask, wr_ctrl, wr_hit;
  logic lo_en;
  assign lo_en = wstrb_r[0] & wstrb_r[1];
  // address decode for the pending write
  always_comb begin
    wr_cfg = 1'b0;
    wr_key = 1'b0;
    wr_cause = 1'b0;
    wr_ret = 1'b0;
    wr_mask = 1'b0;
    wr_ctrl = 1'b0;
    if (hit(awaddr_r, `RCR_OFF_CONFIG)) begin
      wr_cfg = do_wr;
    end else if (hit(awaddr_r, `RCR_OFF_KEY)) begin
      wr_key = do_wr;
    end else if (hit(awaddr_r, `RCR_OFF_CAUSE)) begin
      wr_cause = do_wr;
    end else if (hit(awaddr_r, `RCR_OFF_RETAIN)) begin
      wr_ret = do_wr;
    end else if (hit(awaddr_r, `RCR_OFF_IRQ_MASK)) begin
      wr_mask = do_wr;
    end else if (hit(awaddr_r, `RCR_OFF_CTRL)) begin
      wr_ctrl = do_wr;
    end
  end
  assign wr_hit = wr_cfg | wr_key | wr_cause | wr_ret | wr_mask | wr_ctrl;
  // write response
  always_ff @(posedge mclk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RCR_RESP_OKAY;
    end else if (ce) begin
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `RCR_RESP_OKAY : `RCR_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ***********************************
  // key protection and configuration
  // ***********************************
  rcr_pkg::rcr_key_state_t key_r;
  logic io_retain_disable_r, analog_die_retain_r, sw_unlock_r;
  // only the low half-word is meaningful, so a key needs both low lanes
  always_ff @(posedge mclk) begin
    if (srst) begin
      key_r <= rcr_pkg::RCR_LOCKED;
    end else if (ce) begin
      if (any_ev) begin
        key_r <= rcr_pkg::RCR_LOCKED;
      end else if (wr_key & lo_en & wdata_r[15:0] == `RCR_KEY_FIRST) begin
        key_r <= rcr_pkg::RCR_KEY1_SEEN;
      end else if (wr_key & lo_en & key_r == rcr_pkg::RCR_KEY1_SEEN
                   & wdata_r[15:0] == `RCR_KEY_SECOND) begin
        key_r <= rcr_pkg::RCR_OPEN;
      end else if (do_wr | other_apb_wr) begin
        key_r <= rcr_pkg::RCR_LOCKED;
      end
    end
  end
  // both retain registers are cleared only by srst, pin or power-on reset; sw_unlock_r only by srst
  always_ff @(posedge mclk) begin
    if (srst) begin
      io_retain_disable_r <= 1'b0;
      analog_die_retain_r <= 1'b0;
      sw_unlock_r <= 1'b0;
    end else if (ce) begin
      if (ev_por | ev_ext) begin
        io_retain_disable_r <= 1'b0;
        analog_die_retain_r <= 1'b0;
      end else begin
        if (wr_cfg & wstrb_r[0] & key_r == rcr_pkg::RCR_OPEN & ~other_apb_wr) begin
          io_retain_disable_r <= wdata_r[`RCR_BIT_RETAIN];
        end
        if (wr_ret & wstrb_r[0]) begin
          analog_die_retain_r <= wdata_r[`RCR_BIT_RETAIN];
        end
      end
      if (wr_ctrl & wstrb_r[0]) begin
        sw_unlock_r <= wdata_r[0];
      end
    end
  end

  // ***********************************
  // reset cause and interrupt
  // ***********************************
  logic [`RCR_CAUSE_W-1:0] cause_r, mask_r, cause_set, cause_clr;
  assign cause_set = {ev_sw, ev_wdt, ev_ext, ev_por};
  assign cause_clr = (wr_cause & wstrb_r[0]) ? wdata_r[`RCR_CAUSE_W-1:0] : '0;
  // set wins over clear; no reset source other than srst clears it
  always_ff @(posedge mclk) begin
    if (srst) begin
      cause_r <= '0;
      mask_r <= '0;
    end else if (ce) begin
      cause_r <= (cause_r & ~cause_clr) | cause_set;
      if (wr_mask & wstrb_r[0]) begin
        mask_r <= wdata_r[`RCR_CAUSE_W-1:0];
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(cause_r & mask_r);
    end
  end
  // read path
  always_ff @(posedge mclk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RCR_RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (do_rd) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RCR_RESP_OKAY;
        if (hit(s_axi_araddr, `RCR_OFF_CONFIG)) begin
          s_axi_rdata <= {31'h0000_0000, io_retain_disable_r};
        end else if (hit(s_axi_araddr, `RCR_OFF_KEY)) begin
          s_axi_rdata <= 32'h0000_0000;
        end else if (hit(s_axi_araddr, `RCR_OFF_CAUSE)) begin
          s_axi_rdata <= {28'h000_0000, cause_r};
        end else if (hit(s_axi_araddr, `RCR_OFF_RETAIN)) begin
          s_axi_rdata <= {31'h0000_0000, analog_die_retain_r};
        end else if (hit(s_axi_araddr, `RCR_OFF_IRQ_MASK)) begin
          s_axi_rdata <= {28'h000_0000, mask_r};
        end else if (hit(s_axi_araddr, `RCR_OFF_CTRL)) begin
          s_axi_rdata <= {31'h0000_0000, sw_unlock_r};
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RCR_RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ***********************************
  // reset outputs
  // ***********************************
  logic soft_ev, dl_pend_r;
  assign soft_ev = ev_wdt | ev_sw;
  // a download marks the next reset as leaving sram invalid
  always_ff @(posedge mclk) begin
    if (srst) begin
      dl_pend_r <= 1'b0;
      sram_valid <= 1'b0;
    end else if (ce) begin
      if (any_ev) begin
        dl_pend_r <= 1'b0;
        sram_valid <= ~ev_por & ~dl_pend_r;
      end else if (dl_done) begin
        dl_pend_r <= 1'b1;
      end
    end
  end
  // one-cycle reset strobes; retention masks only the soft sources
  always_ff @(posedge mclk) begin
    if (srst) begin
      sys_rst_req <= 1'b0;
      digital_rst <= 1'b0;
      io_pla_rst <= 1'b0;
      analog_die_rst <= 1'b0;
    end else if (ce) begin
      sys_rst_req <= any_ev;
      digital_rst <= ev_por | ev_ext | (soft_ev & io_retain_disable_r);
      io_pla_rst <= ev_por | ev_ext | (soft_ev & io_retain_disable_r);
      analog_die_rst <= ev_por | ev_ext | (soft_ev & analog_die_retain_r);
    end
  end
  // por indication follows the synchronised power-on level
  always_ff @(posedge mclk) begin
    if (srst) begin
      por_ind_n <= 1'b1;
    end else if (ce) begin
      por_ind_n <= por_n_s;
    end
  end
  // watchdog comes up enabled with its default period after any reset
  always_ff @(posedge mclk) begin
    if (srst) begin
      wdt_enable <= 1'b1;
      wdt_timeout_cycles <= WDT_CYCLES;
    end else if (ce) begin
      if (any_ev) begin
        wdt_enable <= 1'b1;
      end
      wdt_timeout_cycles <= WDT_CYCLES;
    end
  end
endmodule // rcr_reset_ctrl

// File: verification/rcr_partner.sv
// model of the core, watchdog and reset pins beyond the block
`timescale 1ns/1ps
module rcr_partner (
  input wire logic mclk, // system clock
  input wire logic go, // one-cycle request from the bench
  input wire rcr_pkg::rcr_rst_kind_t kind, // which source acts
  input wire logic [15:0] sw_key, // upper half written by the core
  output logic por_n_pin, // power-on detector, low active
  output logic ext_rst_n_pin, // reset pin, low active
  output logic wdt_timeout, // watchdog timeout pulse
  output logic core_rst_wr, // core reset register strobe
  output logic [31:0] core_rst_wdata // core reset register data
);
  logic [2:0] hold_r = 3'h0;
  initial begin
    {por_n_pin, ext_rst_n_pin, wdt_timeout, core_rst_wr} = 4'b1100;
    core_rst_wdata = 32'h0000_0000;
  end
  // pins low four cycles so the synchronisers catch them; idle data toggles to expose misuse
  // watchdog fires only on request, as if software had turned supervision off
  always @(posedge mclk) begin
    wdt_timeout <= go && kind == rcr_pkg::RCR_RST_WDT;
    core_rst_wr <= go && kind == rcr_pkg::RCR_RST_SW;
    core_rst_wdata <= (go && kind == rcr_pkg::RCR_RST_SW) ? {sw_key, 16'h0004} : ~core_rst_wdata;
    if (go && (kind == rcr_pkg::RCR_RST_POR || kind == rcr_pkg::RCR_RST_EXT)) hold_r <= 3'h4;
    else if (hold_r != 3'h0) hold_r <= hold_r - 3'h1;
    por_n_pin <= (go && kind == rcr_pkg::RCR_RST_POR) ? 1'b0 : (hold_r == 3'h1) | por_n_pin;
    ext_rst_n_pin <= (go && kind == rcr_pkg::RCR_RST_EXT) ? 1'b0 : (hold_r == 3'h1) | ext_rst_n_pin;
  end
endmodule // rcr_partner

// File: verification/rcr_reset_ctrl_sva.sv
// port assertions for the reset cause and retention block
`include "rcr_map.svh"
`timescale 1ns/1ps
module rcr_reset_ctrl_sva #(
  parameter longint unsigned WDT_CYCLES = 64'(`RCR_WDT_TIMEOUT_S) * 64'(`RCR_CLK_HZ)
) (
  input wire logic mclk, // system clock
  input wire logic srst, // synchronous reset
  input wire logic por_n_pin, // power-on pin
  input wire logic ext_rst_n_pin, // reset pin
  input wire logic wdt_timeout, // watchdog pulse
  input wire logic core_rst_wr, // core write strobe
  input wire logic [31:0] core_rst_wdata, // core write data
  input wire logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic s_axi_rvalid, // read valid
  input wire logic s_axi_rready, // read ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic sys_rst_req, // reset request pulse
  input wire logic digital_rst, // register reset
  input wire logic io_pla_rst, // io reset
  input wire logic analog_die_rst, // analog die reset
  input wire logic por_ind_n, // power-on indication
  input wire logic sram_valid, // sram trust flag
  input wire logic wdt_enable, // watchdog enable
  input wire logic [63:0] wdt_timeout_cycles // watchdog timeout
);
  logic [4:0] por_hist_r;
  // recent pin levels bound how late the indication may follow the pin
  always_ff @(posedge mclk) begin
    por_hist_r <= {por_hist_r[3:0], por_n_pin};
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // ************************************
  // reset sources, their effects and bus response holding
  // ************************************
  a_wdt_request: assert property (wdt_timeout |=> sys_rst_req)
    else $error("watchdog event gave no reset request");
  a_sw_request: assert property ((core_rst_wr && core_rst_wdata[31:16] == `RCR_SYSRST_KEY) |=> sys_rst_req)
    else $error("software reset key gave no reset request");
  a_ext_full: assert property ($fell(ext_rst_n_pin) |-> ##[1:5] (digital_rst && io_pla_rst && analog_die_rst))
    else $error("pin reset did not reset everything");
  a_por_sram: assert property ($fell(por_n_pin) |-> ##[1:5] !sram_valid)
    else $error("sram still valid after power-on");
  a_por_ind: assert property (!por_ind_n |-> por_hist_r != 5'h1f)
    else $error("power-on indication low without power-on");
  a_wdt_on: assert property (wdt_timeout |=> ##[0:2] wdt_enable)
    else $error("watchdog not enabled after reset");
  a_wdt_count: assert property (wdt_timeout_cycles == 64'(WDT_CYCLES))
    else $error("watchdog timeout count wrong");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped early");
endmodule // rcr_reset_ctrl_sva
bind rcr_reset_ctrl rcr_reset_ctrl_sva #(.WDT_CYCLES(WDT_CYCLES)) u_rcr_reset_ctrl_sva (.*);

// File: verification/rcr_reset_ctrl_tb.sv
// self-checking bench for the reset cause and retention block
`include "rcr_map.svh"
`timescale 1ns/1ps
module rcr_reset_ctrl_tb;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic dl_done = 1'b0;
  logic go = 1'b0;
  logic other_apb_wr = 1'b0;
  rcr_pkg::rcr_rst_kind_t kind = rcr_pkg::RCR_RST_NONE;
  logic [15:0] sw_key = 16'h0000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0000_0000, s_axi_wdata = 32'h0000_0000;
  logic [31:0] s_axi_araddr = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, core_rst_wdata;
  logic por_n_pin, ext_rst_n_pin, wdt_timeout, core_rst_wr;
  logic sys_rst_req, digital_rst, io_pla_rst, analog_die_rst, por_ind_n, sram_valid;
  logic wdt_enable, irq;
  logic [63:0] wdt_timeout_cycles;
  logic [4:0] seen_r = 5'h00;
  logic seen_clr = 1'b0;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  // short timeout count keeps the watchdog figure cheap to check
  rcr_reset_ctrl #(.WDT_CYCLES(64'd1000)) u_rcr_reset_ctrl (.*);
  rcr_partner u_rcr_partner (.*);
  initial forever #12.5 mclk = ~mclk;
  // sticky record of reset pulses, so one-cycle outputs are not missed
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    seen_r <= seen_clr ? 5'h00 :
              seen_r | {digital_rst, sys_rst_req, io_pla_rst, analog_die_rst, !por_ind_n};
    if (cycles == 5000) begin
      bad_count++;
      print_verdict();
    end
  end
  // ************************************
  // bus and event tasks
  // ************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rsp = s_axi_rresp;
    chk(s_axi_rdata, exp);
    @(posedge mclk);
  endtask
  task automatic unlock();
    wr(`RCR_OFF_KEY, 32'(`RCR_KEY_FIRST));
    wr(`RCR_OFF_KEY, 32'(`RCR_KEY_SECOND));
  endtask
  // one request to the partner, then time for pins to pass the synchronisers
  task automatic ev(input rcr_pkg::rcr_rst_kind_t k, input logic [15:0] key);
    kind <= k;
    sw_key <= key;
    go <= 1'b1;
    seen_clr <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    seen_clr <= 1'b0;
    repeat (12) @(posedge mclk);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ************************************
  // tests
  // ************************************
  initial begin
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    rd(`RCR_OFF_CONFIG, 32'h0000_0000);
    chk(32'(rsp), 32'(`RCR_RESP_OKAY));
    rd(`RCR_OFF_KEY, 32'h0000_0000);
    rd(`RCR_OFF_CAUSE, 32'h0000_0000);
    rd(`RCR_OFF_RETAIN, 32'h0000_0000);
    rd(32'h4000_2500, 32'h0000_0000);
    chk(32'(rsp), 32'(`RCR_RESP_SLVERR));
    wr(32'h4000_2500, 32'h0000_ffff);
    chk(32'(rsp), 32'(`RCR_RESP_SLVERR));
    chk(32'(wdt_enable), 32'h0000_0001);
    chk(32'(wdt_timeout_cycles), 32'h0000_03e8);
    $display("test reset values finished");
    unlock();
    wr(`RCR_OFF_CONFIG, 32'h0000_0001);
    rd(`RCR_OFF_CONFIG, 32'h0000_0001);
    wr(`RCR_OFF_CONFIG, 32'h0000_0000);
    rd(`RCR_OFF_CONFIG, 32'h0000_0001);
    unlock();
    other_apb_wr <= 1'b1;
    @(posedge mclk);
    other_apb_wr <= 1'b0;
    wr(`RCR_OFF_CONFIG, 32'h0000_0000);
    rd(`RCR_OFF_CONFIG, 32'h0000_0001);
    $display("test key sequence finished");
    wr(`RCR_OFF_RETAIN, 32'h0000_0001);
    chk(32'(rsp), 32'(`RCR_RESP_OKAY));
    ev(rcr_pkg::RCR_RST_WDT, 16'h0000);
    chk(32'(seen_r), 32'h0000_001e);
    rd(`RCR_OFF_CAUSE, 32'h0000_0004);
    chk(32'(wdt_enable), 32'h0000_0001);
    wr(`RCR_OFF_RETAIN, 32'h0000_0000);
    unlock();
    wr(`RCR_OFF_CONFIG, 32'h0000_0000);
    ev(rcr_pkg::RCR_RST_SW, 16'h05fa);
    chk(32'(seen_r), 32'h0000_0008);
    rd(`RCR_OFF_CAUSE, 32'h0000_000c);
    ev(rcr_pkg::RCR_RST_SW, 16'h05fb);
    chk(32'(seen_r), 32'h0000_0000);
    rd(`RCR_OFF_CAUSE, 32'h0000_000c);
    $display("test watchdog and software finished");
    wr(`RCR_OFF_IRQ_MASK, 32'h0000_0008);
    repeat (2) @(posedge mclk);
    chk(32'(irq), 32'h0000_0001);
    wr(`RCR_OFF_CAUSE, 32'h0000_0000);
    rd(`RCR_OFF_CAUSE, 32'h0000_000c);
    wr(`RCR_OFF_CAUSE, 32'h0000_0008);
    rd(`RCR_OFF_CAUSE, 32'h0000_0004);
    chk(32'(irq), 32'h0000_0000);
    wr(`RCR_OFF_IRQ_MASK, 32'h0000_0004);
    repeat (2) @(posedge mclk);
    chk(32'(irq), 32'h0000_0001);
    wr(`RCR_OFF_IRQ_MASK, 32'h0000_0000);
    repeat (2) @(posedge mclk);
    chk(32'(irq), 32'h0000_0000);
    $display("test clear and interrupt finished");
    unlock();
    wr(`RCR_OFF_CONFIG, 32'h0000_0001);
    wr(`RCR_OFF_KEY, 32'(`RCR_KEY_FIRST));
    ev(rcr_pkg::RCR_RST_EXT, 16'h0000);
    chk(32'(seen_r), 32'h0000_001e);
    rd(`RCR_OFF_CAUSE, 32'h0000_0006);
    rd(`RCR_OFF_CONFIG, 32'h0000_0000);
    wr(`RCR_OFF_KEY, 32'(`RCR_KEY_SECOND));
    wr(`RCR_OFF_CONFIG, 32'h0000_0001);
    rd(`RCR_OFF_CONFIG, 32'h0000_0000);
    ev(rcr_pkg::RCR_RST_POR, 16'h0000);
    chk(32'(seen_r), 32'h0000_001f);
    chk(32'(por_ind_n), 32'h0000_0001);
    chk(32'(sram_valid), 32'h0000_0000);
    rd(`RCR_OFF_CAUSE, 32'h0000_0007);
    ev(rcr_pkg::RCR_RST_SW, 16'h05fa);
    chk(32'(sram_valid), 32'h0000_0001);
    dl_done <= 1'b1;
    @(posedge mclk);
    dl_done <= 1'b0;
    ev(rcr_pkg::RCR_RST_SW, 16'h05fa);
    chk(32'(sram_valid), 32'h0000_0000);
    rd(`RCR_OFF_CAUSE, 32'h0000_000f);
    $display("test pin and power-on finished");
    print_verdict();
  end
endmodule // rcr_reset_ctrl_tb
